// [inc/ocm_pkg.sv]
// Constants shared by the on-chip memory decoder and its writer port.
// Assumes byte addresses on the register bus and a 16-bit CPU space.
package ocm_pkg;

   // Register bus byte offsets
   localparam logic [3:0] OCM_SCR_OFS  = 4'h0;
   localparam logic [3:0] OCM_STAT_OFS = 4'h4;

   // System control register: RAM enable in bit 0, bit 3 reads as one
   localparam int         OCM_RAM_ENABLE_BIT_BIT  = 0;
   localparam logic [7:0] OCM_SCR_RST   = 8'h09;
   localparam logic [7:0] OCM_SCR_WMASK = 8'hF7;
   localparam logic [7:0] OCM_SCR_ONES  = 8'h08;

   // Status register fields
   localparam int OCM_STAT_MODE_LSB = 0;
   localparam int OCM_STAT_WRM_BIT  = 2;

   // CPU address windows
   localparam logic [15:0] OCM_RAM_LO_LARGE = 16'hF780;
   localparam logic [15:0] OCM_RAM_LO_SMALL = 16'hFB80;
   localparam logic [15:0] OCM_RAM_HI       = 16'hFF7F;
   localparam logic [15:0] OCM_ROM_HI_MODE2 = 16'hEF7F;
   localparam logic [15:0] OCM_ROM_HI_MODE3 = 16'hF77F;
   localparam logic [15:0] OCM_ROM_HI_SMALL = 16'h7FFF;
   localparam int          OCM_RAM_WORDS    = 1024;
   localparam int          OCM_PROM_BYTES   = 63360;

   localparam logic [7:0]  OCM_ERASED  = 8'hFF;
   localparam logic [15:0] OCM_UNREAD  = 16'hFFFF;

   // Mode pin codes {hi, lo}
   localparam logic [1:0] OCM_MODE1 = 2'h1;
   localparam logic [1:0] OCM_MODE2 = 2'h2;
   localparam logic [1:0] OCM_MODE3 = 2'h3;

   typedef enum logic [1:0] {
      OCM_CS_IDLE = 2'b01,
      OCM_CS_DATA = 2'b10
   } ocm_cpu_state_t;

endpackage

// [inc/ocm_writer_if.sv]
// Carries synchronised pin state from the writer port to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface ocm_writer_if;
   logic [1:0]  modePins;
   logic        writerMode;
   logic        progStb;
   logic        verifyEn;
   logic [16:0] promAddr;
   logic [7:0]  promData;

   modport port (output modePins, writerMode, progStb, verifyEn,
                 promAddr, promData);
   modport core (input modePins, writerMode, progStb, verifyEn,
                 promAddr, promData);
endinterface
`default_nettype wire

// [verilog/ocm_writer_port.sv]
// Synchronises mode and programmer pins and decodes writer sub-modes.
// Assumes all pin inputs are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module ocm_writer_port
   import ocm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        modeSelectHi,
   input  wire logic        modeSelectLo,
   input  wire logic        standbyInputN,
   input  wire logic        writerSelectPinA,
   input  wire logic        writerSelectPinB,
   input  wire logic        chipEnableN,
   input  wire logic        outputEnableN,
   input  wire logic        programPulsePinN,
   input  wire logic [16:0] promAddressPins,
   input  wire logic [7:0]  promDataPinsIn,
   ocm_writer_if.port       wr
);
   localparam int W = 33;

   logic [W-1:0] meta_ff, sync_ff, nxt_meta, nxt_sync;
   logic         pgmOld_ff, nxt_pgmOld;
   logic         ceN, oeN, pgmN, wrm;

   always_comb begin
      nxt_meta = {modeSelectHi, modeSelectLo, standbyInputN,
                  writerSelectPinA, writerSelectPinB, chipEnableN,
                  outputEnableN, programPulsePinN, promAddressPins,
                  promDataPinsIn};
      nxt_sync = meta_ff;
      nxt_pgmOld = sync_ff[25];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_ff   <= '1;
         sync_ff   <= '1;
         pgmOld_ff <= 1'b1;
      end else begin
         meta_ff   <= nxt_meta;
         sync_ff   <= nxt_sync;
         pgmOld_ff <= nxt_pgmOld;
      end
   end

   assign ceN  = sync_ff[27];
   assign oeN  = sync_ff[26];
   assign pgmN = sync_ff[25];
   assign wrm  = ~sync_ff[32] & ~sync_ff[31] & ~sync_ff[30]
                 & sync_ff[29] & sync_ff[28];

   assign wr.modePins   = sync_ff[32:31];
   assign wr.writerMode = wrm;
   // Falling edge of program strobe counts once per pulse
   assign wr.progStb  = wrm & ~ceN & oeN & ~pgmN & pgmOld_ff;
   assign wr.verifyEn = wrm & ~ceN & ~oeN & pgmN;
   assign wr.promAddr = sync_ff[24:8];
   assign wr.promData = sync_ff[7:0];
endmodule
`default_nettype wire

// [verilog/ocm_mem_ctrl.sv]
// On-chip RAM/ROM decoder with writer-mode PROM access.
// Assumes an Avalon-MM master on clk and a CPU core on the same clock.
// Operation
// - Single-chip mode, RAM enabled: RAM window goes to on-chip RAM.
// - Single-chip mode, RAM disabled: writes to RAM window ignored.
// - Single-chip mode, RAM disabled: reads from RAM window return FF.
// - ROM path is 16 bits; byte and word reads take two states.
// - Mode 1 maps ROM externally; modes 2 and 3 enable on-chip ROM.
// - Large part: ROM up to EF7F in mode 2, F77F in mode 3.
// - Both mode pins, standby low, select pins high enter writer mode.
// - Write on CE low OE high PROGRAM_PULSE_PIN low; verify drives; else float.
// - Programmed bits cannot return to the erased state.
// - RAM enable set to one at reset, kept through standby.
// - RAM enable sits in bit 0 of the system control register.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module ocm_mem_ctrl
   import ocm_pkg::*;
#(
   parameter bit SMALL_PART = 1'b0
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Avalon-MM register slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // CPU memory port
   input  wire logic        cpuReq,
   input  wire logic        cpuWrite,
   input  wire logic        cpuWord,
   input  wire logic [15:0] cpuAddr,
   input  wire logic [15:0] cpuWdata,
   output logic [15:0]      cpuRdata,
   output logic             cpuAck,
   output logic             cpuExt,
   // Mode and programmer pins
   input  wire logic        modeSelectHi,
   input  wire logic        modeSelectLo,
   input  wire logic        standbyInputN,
   input  wire logic        writerSelectPinA,
   input  wire logic        writerSelectPinB,
   input  wire logic        chipEnableN,
   input  wire logic        outputEnableN,
   input  wire logic        programPulsePinN,
   input  wire logic [16:0] promAddressPins,
   input  wire logic [7:0]  promDataPinsIn,
   output logic [7:0]       promDataPinsOut,
   output logic             promDataPinsOe,
   output logic             writerModeActive
);
   localparam logic [15:0] RAM_LO =
      SMALL_PART ? OCM_RAM_LO_SMALL : OCM_RAM_LO_LARGE;

   function automatic logic inWin(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
      inWin = (a >= lo) && (a <= hi);
   endfunction

   ocm_writer_if wr ();

   ocm_writer_port u_port (
      .clk              (clk),
      .sys_rst          (sys_rst),
      .modeSelectHi     (modeSelectHi),
      .modeSelectLo     (modeSelectLo),
      .standbyInputN    (standbyInputN),
      .writerSelectPinA (writerSelectPinA),
      .writerSelectPinB (writerSelectPinB),
      .chipEnableN      (chipEnableN),
      .outputEnableN    (outputEnableN),
      .programPulsePinN (programPulsePinN),
      .promAddressPins  (promAddressPins),
      .promDataPinsIn   (promDataPinsIn),
      .wr               (wr)
   );

   logic [15:0] ram  [OCM_RAM_WORDS];
   logic [7:0]  prom [OCM_PROM_BYTES];

   // Register bus
   logic [7:0]  scr_ff, nxt_scr;
   logic        wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        busDone;
   logic        ramEn;

   assign busDone = (avs_read | avs_write) & ~wait_ff;
   assign ramEn   = scr_ff[OCM_RAM_ENABLE_BIT_BIT];

   always_comb begin
      nxt_scr   = scr_ff;
      nxt_wait  = ~((avs_read | avs_write) & wait_ff);
      nxt_rdata = rdata_ff;
      if ((avs_read | avs_write) & wait_ff) begin
         nxt_rdata = 32'h0000_0000;
         if (avs_address == OCM_SCR_OFS)
            nxt_rdata[7:0] = scr_ff | OCM_SCR_ONES;
         else if (avs_address == OCM_STAT_OFS) begin
            nxt_rdata[OCM_STAT_MODE_LSB +: 2] = wr.modePins;
            nxt_rdata[OCM_STAT_WRM_BIT]       = wr.writerMode;
         end
      end
      if (busDone & avs_write & (avs_address == OCM_SCR_OFS))
         nxt_scr = (scr_ff & ~OCM_SCR_WMASK)
                 | (avs_writedata[7:0] & OCM_SCR_WMASK);
   end

   // Reset and accepted register writes set the RAM enable; no standby path touches it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scr_ff   <= OCM_SCR_RST;
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         scr_ff   <= nxt_scr;
         wait_ff  <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;

   // CPU access decode
   ocm_cpu_state_t cs_ff, nxt_cs;
   logic [15:0] crd_ff, nxt_crd;
   logic        ack_ff, nxt_ack, ext_ff, nxt_ext;
   logic        ramWin, romHit, ramHit, ramMute, take;
   logic [15:0] romHi;
   logic [9:0]  ramIdx;
   logic [15:0] ramWord, romWord;
   logic        ramWe;
   logic [1:0]  ramBe;

   always_comb begin
      romHi = SMALL_PART ? OCM_ROM_HI_SMALL
            : (wr.modePins == OCM_MODE2) ? OCM_ROM_HI_MODE2
            : OCM_ROM_HI_MODE3;
      ramWin = inWin(cpuAddr, RAM_LO, OCM_RAM_HI);
      romHit = (wr.modePins == OCM_MODE2 || wr.modePins == OCM_MODE3)
               && inWin(cpuAddr, 16'h0000, romHi);
      ramHit = ramWin & ramEn;
      ramMute = ramWin & ~ramEn & (wr.modePins == OCM_MODE3);
   end

   assign ramIdx  = 10'((cpuAddr - RAM_LO) >> 1);
   assign ramWord = ram[ramIdx];
   assign romWord = {prom[16'(cpuAddr & 16'hFFFE)],
                     prom[16'(cpuAddr | 16'h0001)]};
   assign take    = (cs_ff == OCM_CS_IDLE) & cpuReq & ~wr.writerMode;

   always_comb begin
      nxt_cs  = cs_ff;
      nxt_crd = crd_ff;
      nxt_ack = 1'b0;
      nxt_ext = ext_ff;
      ramWe   = 1'b0;
      ramBe   = 2'b00;
      case (cs_ff)
         OCM_CS_IDLE: begin
            if (take) begin
               // Second state delivers data and ack
               nxt_cs  = OCM_CS_DATA;
               nxt_ack = 1'b1;
               nxt_ext = ~(romHit | ramHit | ramMute);
               nxt_crd = 16'h0000;
               if (!cpuWrite) begin
                  if (ramMute)
                     nxt_crd = cpuWord ? OCM_UNREAD
                             : {8'h00, OCM_ERASED};
                  else if (ramHit)
                     nxt_crd = cpuWord ? ramWord
                             : {8'h00, cpuAddr[0] ? ramWord[7:0]
                                                  : ramWord[15:8]};
                  else if (romHit)
                     nxt_crd = cpuWord ? romWord
                             : {8'h00, cpuAddr[0] ? romWord[7:0]
                                                  : romWord[15:8]};
               end else if (ramHit) begin
                  ramWe = 1'b1;
                  ramBe = cpuWord ? 2'b11
                        : (cpuAddr[0] ? 2'b01 : 2'b10);
               end
            end
         end
         OCM_CS_DATA: nxt_cs = OCM_CS_IDLE;
         default:     nxt_cs = OCM_CS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cs_ff  <= OCM_CS_IDLE;
         crd_ff <= 16'h0000;
         ack_ff <= 1'b0;
         ext_ff <= 1'b0;
      end else begin
         cs_ff  <= nxt_cs;
         crd_ff <= nxt_crd;
         ack_ff <= nxt_ack;
         ext_ff <= nxt_ext;
      end
   end

   // Big-endian byte lanes: even address is the high byte
   always_ff @(posedge clk) begin
      if (ramWe & ramBe[1])
         ram[ramIdx][15:8] <= cpuWord ? cpuWdata[15:8] : cpuWdata[7:0];
      if (ramWe & ramBe[0])
         ram[ramIdx][7:0] <= cpuWord ? cpuWdata[7:0]
                           : (cpuAddr[0] ? cpuWdata[7:0] : 8'h00);
   end

   assign cpuRdata = crd_ff;
   assign cpuAck   = ack_ff;
   assign cpuExt   = ext_ff;

   // Writer mode PROM access
   logic        promIn;
   logic [15:0] pIdx;
   logic [7:0]  pdo_ff, nxt_pdo;
   logic        poe_ff, nxt_poe, wrm_ff, nxt_wrm;

   assign promIn = (wr.promAddr <= 17'(romHi));
   assign pIdx   = wr.promAddr[15:0];

   // Cells only discharge: a pulse can clear bits, never set them
   always_ff @(posedge clk) begin
      if (wr.progStb & promIn)
         prom[pIdx] <= prom[pIdx] & wr.promData;
   end

   always_comb begin
      nxt_wrm = wr.writerMode;
      nxt_poe = wr.verifyEn;
      nxt_pdo = wr.verifyEn ? (promIn ? prom[pIdx] : OCM_ERASED) : 8'h00;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pdo_ff <= 8'h00;
         poe_ff <= 1'b0;
         wrm_ff <= 1'b0;
      end else begin
         pdo_ff <= nxt_pdo;
         poe_ff <= nxt_poe;
         wrm_ff <= nxt_wrm;
      end
   end

   assign promDataPinsOut  = pdo_ff;
   assign promDataPinsOe   = poe_ff;
   assign writerModeActive = wrm_ff;

   // Blank part at power-up; reprogramming after that only clears bits
   initial begin
      for (int i = 0; i < OCM_PROM_BYTES; i++)
         prom[i] = OCM_ERASED;
   end
endmodule
`default_nettype wire

// [tb/ocm_mem_ctrl_chk.sv]
// Port-level checks for the on-chip memory decoder.
// Bound to every ocm_mem_ctrl; one clock domain, default part size.
`timescale 1ns/1ns
`default_nettype none
module ocm_mem_ctrl_chk
   import ocm_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        cpuReq,
   input wire logic        cpuWrite,
   input wire logic        cpuWord,
   input wire logic [15:0] cpuAddr,
   input wire logic [15:0] cpuRdata,
   input wire logic        cpuAck,
   input wire logic        cpuExt,
   input wire logic        modeSelectHi,
   input wire logic        modeSelectLo,
   input wire logic        chipEnableN,
   input wire logic        outputEnableN,
   input wire logic        programPulsePinN,
   input wire logic        promDataPinsOe,
   input wire logic        writerModeActive
);
   logic ramOn_ff;
   logic nxt_ramOn;
   logic inRam;
   logic single;
   logic verifyPins;

   assign inRam  = cpuAddr >= OCM_RAM_LO_LARGE && cpuAddr <= OCM_RAM_HI;
   assign single = modeSelectHi && modeSelectLo;
   assign verifyPins = !chipEnableN && !outputEnableN && programPulsePinN;

   // Shadow of the RAM enable, tracked from accepted writes
   always_comb begin
      nxt_ramOn = ramOn_ff;
      if (avs_write && !avs_waitrequest && avs_address == OCM_SCR_OFS) begin
         nxt_ramOn = avs_writedata[OCM_RAM_ENABLE_BIT_BIT];
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ramOn_ff <= 1'b1;
      end else begin
         ramOn_ff <= nxt_ramOn;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_bus_one_wait: assert property ((avs_read || avs_write) &&
      avs_waitrequest |=> !avs_waitrequest) else $error("bus wait not one");
   chk_scr_read: assert property (avs_read && !avs_waitrequest &&
      avs_address == OCM_SCR_OFS |-> avs_readdata[3] &&
      avs_readdata[OCM_RAM_ENABLE_BIT_BIT] == ramOn_ff) else $error("bad scr read");
   chk_ack_next: assert property ($rose(cpuReq) &&
      !writerModeActive |=> cpuAck) else $error("ack not in two states");
   chk_ack_pulse: assert property (cpuAck |=> !cpuAck)
      else $error("ack longer than one cycle");
   chk_writer_quiet: assert property (writerModeActive |-> !cpuAck)
      else $error("cpu acked in writer mode");
   chk_ram_routed: assert property (cpuAck && single && ramOn_ff &&
      inRam |-> !cpuExt) else $error("ram access sent outside");
   chk_ram_off_ones: assert property (cpuAck && !cpuWrite &&
      single && !ramOn_ff && inRam |->
      cpuRdata == (cpuWord ? OCM_UNREAD : 16'h00FF))
      else $error("disabled ram read not ones");
   chk_rom_mode1_ext: assert property (cpuAck && !modeSelectHi &&
      modeSelectLo && cpuAddr <= OCM_ROM_HI_MODE3 |-> cpuExt)
      else $error("rom not external in mode 1");
   chk_rom_on_chip: assert property (cpuAck && modeSelectHi &&
      cpuAddr <= (modeSelectLo ? OCM_ROM_HI_MODE3 : OCM_ROM_HI_MODE2)
      |-> !cpuExt) else $error("rom access sent outside");
   chk_verify_drive: assert property (promDataPinsOe |->
      $past(verifyPins, 3))
      else $error("data pins driven outside verify");
endmodule
bind ocm_mem_ctrl ocm_mem_ctrl_chk i_ocm_mem_ctrl_chk (.clk, .sys_rst,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .cpuReq, .cpuWrite, .cpuWord, .cpuAddr, .cpuRdata,
   .cpuAck, .cpuExt, .modeSelectHi, .modeSelectLo, .chipEnableN,
   .outputEnableN, .programPulsePinN, .promDataPinsOe, .writerModeActive);
`default_nettype wire

// [tb/ocm_prog_model.sv]
// Byte-wide PROM programmer driving the writer-mode pins.
// Assumes the bench resolves the shared data pins into pinData.
`timescale 1ns/1ns
`default_nettype none
module ocm_prog_model
   import ocm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] pinData,
   output logic            ceN,
   output logic            oeN,
   output logic            pgmN,
   output logic [16:0]     addr,
   output logic [7:0]      dOut,
   output logic            dOe
);
   initial begin
      ceN  = 1'b1;
      oeN  = 1'b1;
      pgmN = 1'b1;
      addr = 17'h00000;
      dOut = 8'h00;
      dOe  = 1'b0;
   end

   task automatic verify(input logic [16:0] a, output logic [7:0] q);
      @(posedge clk);
      addr <= a;
      ceN  <= 1'b0;
      oeN  <= 1'b0;
      repeat (6) @(posedge clk);
      q = pinData;
      ceN <= 1'b1;
      oeN <= 1'b1;
   endtask

   // Pulse, read back, try up to three times in all
   task automatic prog(input logic [16:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      int tries;
      if (a > 17'h0F77F) begin
         d = OCM_ERASED;
      end
      q = ~d;
      for (tries = 0; tries < 3 && q !== d; tries++) begin
         @(posedge clk);
         addr <= a;
         dOut <= d;
         dOe  <= 1'b1;
         ceN  <= 1'b0;
         repeat (4) @(posedge clk);
         pgmN <= 1'b0;
         repeat (4) @(posedge clk);
         pgmN <= 1'b1;
         repeat (4) @(posedge clk);
         dOe  <= 1'b0;
         verify(a, q);
      end
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench: register bus, CPU port and writer mode.
// Assumes the programmer model and the bound checker are compiled in.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ocm_pkg::*;
   logic        clk, sys_rst;
   logic [3:0]  avAddr = 4'h0;
   logic        avRd = 1'b0, avWr = 1'b0, cReq = 1'b0, cWr = 1'b0;
   logic        cWord = 1'b0, mHi = 1'b1, mLo = 1'b1, stbyN = 1'b1;
   logic        selA = 1'b0, selB = 1'b0, avWait, cAck, cExt, devOe;
   logic        wrAct, ceN, oeN, pgmN, mOe;
   logic [31:0] avWdat = 32'h0, avRdat;
   logic [15:0] cAddr = 16'h0, cWdat = 16'h0, cRdat;
   logic [16:0] pAddr;
   logic [7:0]  mD, devOut, pinBus, lastBus = 8'h00;
   int          n_fail = 0, cmp_count = 0;

   // Released pins show a moving pattern, never the last value
   assign pinBus = devOe ? devOut : mOe ? mD : ~lastBus;
   always @(posedge clk) lastBus <= pinBus;

   ocm_mem_ctrl i_ocm_mem_ctrl (.clk, .sys_rst, .avs_address(avAddr),
      .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWdat),
      .avs_readdata(avRdat), .avs_waitrequest(avWait), .cpuReq(cReq),
      .cpuWrite(cWr), .cpuWord(cWord), .cpuAddr(cAddr), .cpuWdata(cWdat),
      .cpuRdata(cRdat), .cpuAck(cAck), .cpuExt(cExt), .modeSelectHi(mHi),
      .modeSelectLo(mLo), .standbyInputN(stbyN), .writerSelectPinA(selA),
      .writerSelectPinB(selB), .chipEnableN(ceN), .outputEnableN(oeN),
      .programPulsePinN(pgmN), .promAddressPins(pAddr),
      .promDataPinsIn(pinBus), .promDataPinsOut(devOut),
      .promDataPinsOe(devOe), .writerModeActive(wrAct));
   ocm_prog_model i_ocm_prog_model (.clk, .pinData(pinBus), .ceN, .oeN,
      .pgmN, .addr(pAddr), .dOut(mD), .dOe(mOe));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic av(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avRd   <= !w;
      avWr   <= w;
      avAddr <= a;
      avWdat <= d;
      do @(posedge clk); while (avWait !== 1'b0);
      q = avRdat;
      avRd <= 1'b0;
      avWr <= 1'b0;
   endtask

   task automatic cpu(input logic w, input logic wd, input logic [15:0] a,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic e);
      @(posedge clk);
      cReq  <= 1'b1;
      cWr   <= w;
      cWord <= wd;
      cAddr <= a;
      cWdat <= d;
      do @(posedge clk); while (cAck !== 1'b1);
      q = cRdat;
      e = cExt;
      cReq <= 1'b0;
   endtask

   // Order: hi, lo, standby, select a, select b; waits out the sync
   task automatic pins(input logic [4:0] p);
      @(posedge clk);
      {mHi, mLo, stbyN, selA, selB} <= p;
      repeat (5) @(posedge clk);
   endtask

   task automatic t_regs;
      logic [31:0] q;
      av(1'b0, OCM_SCR_OFS, 32'h0, q); chk(q, 32'h09);
      av(1'b1, OCM_SCR_OFS, 32'h0, q);
      av(1'b0, OCM_SCR_OFS, 32'h0, q); chk(q, 32'h08);
      av(1'b0, 4'h8, 32'h0, q); chk(q, 32'h0);
      av(1'b0, OCM_STAT_OFS, 32'h0, q); chk(q, 32'h3);
      av(1'b1, OCM_SCR_OFS, 32'h01, q);
      $display("test regs done");
   endtask

   task automatic t_ram;
      logic [31:0] r;
      logic [15:0] q;
      logic        e;
      cpu(1'b1, 1'b1, 16'hF780, 16'h1234, q, e);
      cpu(1'b0, 1'b1, 16'hF780, 16'h0, q, e); chk(q, 16'h1234);
      chk(e, 1'b0);
      cpu(1'b1, 1'b0, 16'hFF7F, 16'h00A5, q, e);
      cpu(1'b0, 1'b0, 16'hFF7F, 16'h0, q, e); chk(q, 16'h00A5);
      cpu(1'b0, 1'b0, 16'hF781, 16'h0, q, e); chk(q, 16'h0034);
      av(1'b1, OCM_SCR_OFS, 32'h0, r);
      cpu(1'b1, 1'b1, 16'hF780, 16'hBEEF, q, e);
      cpu(1'b0, 1'b1, 16'hF780, 16'h0, q, e); chk(q, 16'hFFFF);
      cpu(1'b0, 1'b0, 16'hF781, 16'h0, q, e); chk(q, 16'h00FF);
      av(1'b1, OCM_SCR_OFS, 32'h01, r);
      cpu(1'b0, 1'b1, 16'hF780, 16'h0, q, e); chk(q, 16'h1234);
      $display("test ram done");
   endtask

   task automatic t_modes;
      logic [15:0] q;
      logic        e;
      pins(5'b01100);
      cpu(1'b0, 1'b1, 16'h0000, 16'h0, q, e); chk(e, 1'b1);
      pins(5'b10100);
      cpu(1'b0, 1'b1, 16'hEF7E, 16'h0, q, e); chk(e, 1'b0);
      cpu(1'b0, 1'b0, 16'hEF80, 16'h0, q, e); chk(e, 1'b1);
      pins(5'b11100);
      cpu(1'b0, 1'b0, 16'hF77F, 16'h0, q, e); chk(e, 1'b0);
      $display("test modes done");
   endtask

   task automatic t_writer;
      logic [31:0] r;
      logic [7:0]  b;
      logic [15:0] q;
      logic        e;
      pins(5'b00011); chk(wrAct, 1'b1);
      av(1'b0, OCM_STAT_OFS, 32'h0, r); chk(r, 32'h4);
      cReq <= 1'b1;
      repeat (6) @(posedge clk);
      chk(cAck, 1'b0);
      cReq <= 1'b0;
      i_ocm_prog_model.prog(17'h0, 8'h5A, b); chk(b, 8'h5A);
      i_ocm_prog_model.prog(17'h0, 8'hFF, b); chk(b, 8'h5A);
      i_ocm_prog_model.prog(17'h0, 8'h0F, b); chk(b, 8'h0A);
      i_ocm_prog_model.prog(17'h0F780, 8'h00, b); chk(b, 8'hFF);
      repeat (4) @(posedge clk);
      chk(devOe, 1'b0);
      pins(5'b11100); chk(wrAct, 1'b0);
      cpu(1'b0, 1'b1, 16'h0000, 16'h0, q, e); chk(q, 16'h0AFF);
      $display("test writer done");
   endtask

   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      #(50 * 20000);
      n_fail++;
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_regs();
      t_ram();
      t_modes();
      t_writer();
      wrap_up();
   end
endmodule
`default_nettype wire
